// File: tb/tb_usm_serial_port.sv
`timescale 1ns/1ps
module tb_usm_serial_port import usm_pkg::*; ();
  // ********
  // signals
  // ********
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic line;
  usm_pins_t pins;
  logic pclr = 1'b1;
  logic [7:0] ppat = 8'h3c;
  logic [15:0] pcap;
  int pn;
  logic pasy = 1'b0;
  logic pld = 1'b0;
  logic [10:0] pfrm = 11'h7ff;
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] q;
  logic [7:0] ridx [9] = '{IDX_INTCTL, IDX_PIRF, IDX_RCSC, IDX_TXBUF,
    IDX_RXBUF, IDX_PIEN, IDX_TXSC, IDX_BAUD, 8'h20};
  logic [7:0] rexp [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    RST_TXSC, 8'h00, 8'h00};

  usm_serial_port usm_serial_port_inst (.mclk(mclk), .srst(srst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .line_dat_i(line), .pins(pins), .irq(irq));
  usm_partner_model usm_partner_model_inst (.mclk(mclk), .clr(pclr),
    .pins(pins), .pat(ppat), .asy(pasy), .ld(pld), .frm(pfrm),
    .line(line), .cap(pcap), .nbits(pn));

  // 25 MHz core clock
  always #20 mclk = ~mclk;

  // ********
  // tasks
  // ********
  task automatic chk(input string nm, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] idx, d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    wdat <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    if (n >= 50) error_cnt++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask : wb

  task automatic rc(input logic [7:0] idx, e);
    wb(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), {8'h00, q}, {8'h00, e});
  endtask : rc

  // poll a status bit, bounded
  task automatic wt(input logic [7:0] idx, input int b, input logic v);
    int n;
    n = 0;
    do begin
      wb(1'b0, idx, 8'h00);
      n++;
    end while (q[b] !== v && n < 300);
    chk($sformatf("bit %0d of %h", b, idx), {15'h0, q[b]}, {15'h0, v});
  endtask : wt

  task automatic wn(input int n);
    for (int i = 0; i < 3000 && pn < n; i++) @(posedge mclk);
  endtask : wn

  task automatic pulse_clr;
    pclr <= 1'b1;
    @(posedge mclk);
    pclr <= 1'b0;
  endtask : pulse_clr

  // hand one async frame to the partner
  task automatic snd(input logic [10:0] f);
    pfrm <= f;
    pld <= 1'b1;
    @(posedge mclk);
    pld <= 1'b0;
  endtask : snd

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    wrap_up;
  end

  // ********
  // tests
  // ********
  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    pclr <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rc(ridx[i], rexp[i]);
    end
    $display("reset values done");
    wb(1'b1, IDX_BAUD, 8'h03);
    wb(1'b1, IDX_RCSC, 8'h80);
    wb(1'b1, IDX_PIEN, 8'h10);
    wb(1'b1, IDX_INTCTL, 8'hc0);
    wb(1'b1, IDX_TXSC, 8'hb0);
    rc(IDX_PIRF, 8'h10);
    chk("irq", {15'h0, irq}, 16'h1);
    wb(1'b1, IDX_PIRF, 8'h00);
    rc(IDX_PIRF, 8'h10);
    pulse_clr;
    wb(1'b1, IDX_TXBUF, 8'ha5);
    wb(1'b1, IDX_TXBUF, 8'h3c);
    rc(IDX_TXSC, 8'hb0);
    rc(IDX_PIRF, 8'h00);
    chk("irq", {15'h0, irq}, 16'h0);
    wn(16);
    wt(IDX_TXSC, B_SHIFTER_EMPTY, 1'b1);
    chk("tx bits", pn[15:0], 16'h0010);
    chk("tx words", pcap, 16'h3ca5);
    rc(IDX_PIRF, 8'h10);
    wb(1'b1, IDX_INTCTL, 8'h80);
    repeat (3) @(posedge mclk);
    chk("irq", {15'h0, irq}, 16'h0);
    $display("transmit done");
    wb(1'b1, IDX_TXSC, 8'hf1);
    pulse_clr;
    wb(1'b1, IDX_TXBUF, 8'h5a);
    wn(9);
    wt(IDX_TXSC, B_SHIFTER_EMPTY, 1'b1);
    chk("tx nine", {7'h0, pcap[15:7]}, 16'h015a);
    $display("nine bit done");
    wb(1'b1, IDX_TXSC, 8'hb0);
    pulse_clr;
    wb(1'b1, IDX_TXBUF, 8'hff);
    wn(2);
    wb(1'b1, IDX_TXSC, 8'h90);
    chk("clk oe", {15'h0, pins.clk_oe}, 16'h0);
    chk("dat oe", {15'h0, pins.dat_oe}, 16'h0);
    rc(IDX_TXSC, 8'h92);
    $display("abort done");
    wb(1'b1, IDX_TXSC, 8'hb0);
    pulse_clr;
    wb(1'b1, IDX_TXBUF, 8'h81);
    wn(2);
    wb(1'b1, IDX_RCSC, 8'ha0);
    chk("dat oe", {15'h0, pins.dat_oe}, 16'h0);
    chk("clk oe", {15'h0, pins.clk_oe}, 16'h1);
    wt(IDX_PIRF, B_RX_READY_FLAG, 1'b1);
    rc(IDX_RCSC, 8'h80);
    chk("dat oe", {15'h0, pins.dat_oe}, 16'h1);
    rc(IDX_RXBUF, 8'h3c);
    rc(IDX_PIRF, 8'h10);
    wt(IDX_TXSC, B_SHIFTER_EMPTY, 1'b1);
    $display("single receive done");
    wb(1'b1, IDX_TXSC, 8'h90);
    pulse_clr;
    wb(1'b1, IDX_RCSC, 8'h90);
    wt(IDX_RCSC, B_OVERRUN_ERROR, 1'b1);
    rc(IDX_RCSC, 8'h92);
    wb(1'b1, IDX_RCSC, 8'h80);
    rc(IDX_RCSC, 8'h80);
    rc(IDX_RXBUF, 8'h3c);
    wt(IDX_PIRF, B_RX_READY_FLAG, 1'b1);
    rc(IDX_RXBUF, 8'h3c);
    wt(IDX_PIRF, B_RX_READY_FLAG, 1'b0);
    $display("overrun done");
    wb(1'b1, IDX_TXSC, 8'h04);
    wb(1'b1, IDX_BAUD, 8'h00);
    wb(1'b1, IDX_RCSC, 8'hc0);
    pasy <= 1'b1;
    wb(1'b1, IDX_RCSC, 8'hd0);
    snd({1'b1, 1'b1, 8'ha6, 1'b0});
    wt(IDX_PIRF, B_RX_READY_FLAG, 1'b1);
    rc(IDX_RCSC, 8'hd1);
    rc(IDX_RXBUF, 8'ha6);
    repeat (16) @(posedge mclk);
    snd({1'b0, 1'b0, 8'h5b, 1'b0});
    wt(IDX_PIRF, B_RX_READY_FLAG, 1'b1);
    rc(IDX_RCSC, 8'hd4);
    rc(IDX_RXBUF, 8'h5b);
    $display("async receive done");
    wrap_up;
  end
endmodule : tb_usm_serial_port

// File: tb/usm_partner_model.sv
`timescale 1ns/1ps
// ********
// far-side serial device
// ********
module usm_partner_model import usm_pkg::*; (
  input wire logic mclk,  // core clock
  input wire logic clr,  // clear capture
  input wire usm_pins_t pins,  // device pin drive
  input wire logic [7:0] pat,  // word sent back
  input wire logic asy,  // send async frames instead
  input wire logic ld,  // load one async frame
  input wire logic [10:0] frm,  // async frame, start bit first
  output logic line,  // data line level
  output logic [15:0] cap,  // captured bits
  output int nbits  // captured count
);
  logic clk_q;
  logic [2:0] k;
  logic [10:0] fsr;
  logic [3:0] fdiv;
  // device owns the line while it drives, else we send pat or a frame
  assign line = pins.dat_oe ? pins.dat_o :
                (asy ? fsr[0] : pat[k]);
  // async frame shifter, one bit per sixteen clocks, idle high
  always_ff @(posedge mclk) begin
    if (clr) begin
      fsr <= 11'h7ff;
      fdiv <= 4'h0;
    end else if (ld) begin
      fsr <= frm;
      fdiv <= 4'h0;
    end else begin
      fdiv <= fdiv + 4'h1;
      if (fdiv == 4'hf) fsr <= {1'b1, fsr[10:1]};
    end
  end
  // sample on falling shift clock, advance our bit after it
  always_ff @(posedge mclk) begin
    clk_q <= pins.clk_o;
    if (clr) begin
      nbits <= 0;
      k <= 3'h0;
      cap <= 16'h0;
    end else if (clk_q && !pins.clk_o && pins.clk_oe) begin
      if (pins.dat_oe) begin
        cap <= {pins.dat_o, cap[15:1]};
        nbits <= nbits + 1;
      end else begin
        k <= k + 3'h1;
      end
    end else if (pins.dat_oe) begin
      k <= 3'h0;
    end
  end
endmodule : usm_partner_model

// File: tb/usm_serial_port_sva.sv
`timescale 1ns/1ps
// ********
// port checker
// ********
module usm_serial_port_chk import usm_pkg::*; #(
  parameter int DEPTH = RX_DEPTH  // queue depth
) (
  input wire logic mclk,  // clock
  input wire logic srst,  // reset
  input wire logic wb_cyc_i,  // cycle
  input wire logic wb_stb_i,  // strobe
  input wire logic wb_we_i,  // write
  input wire logic [9:0] wb_adr_i,  // address
  input wire logic [3:0] wb_sel_i,  // selects
  input wire logic [31:0] wb_dat_i,  // write data
  input wire logic [31:0] wb_dat_o,  // read data
  input wire logic wb_ack_o,  // ack
  input wire logic line_dat_i,  // data line
  input wire usm_pins_t pins,  // pin drive
  input wire logic irq  // interrupt
);
  logic wr;
  // write accepted at this edge
  assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than a cycle");
  ack_answer_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  read_pad_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  data_on_rise_a: assert property (
    pins.dat_oe && $past(pins.dat_oe) && $changed(pins.dat_o)
    |-> $rose(pins.clk_o))
    else $error("data moved off rising clock");
  tx_enable_abort_a: assert property (
    wr && wb_adr_i[9:2] == IDX_TXSC && !wb_dat_i[B_TX_ENABLE] |=> !pins.dat_oe)
    else $error("data still driven after transmit off");
  rx_release_a: assert property (
    wr && wb_adr_i[9:2] == IDX_RCSC && (wb_dat_i[B_SINGLE_RX_ENABLE] || wb_dat_i[B_CONTINUOUS_RX_ENABLE])
    |=> !pins.dat_oe)
    else $error("data driven while receiving");
  rx_keeps_clk_a: assert property (
    wr && wb_adr_i[9:2] == IDX_RCSC && wb_dat_i[B_SINGLE_RX_ENABLE] &&
    wb_dat_i[B_PORT_ENABLE] && pins.clk_oe |=> pins.clk_oe)
    else $error("clock released on receive");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("interrupt dropped without access");
  // main scenarios reached
  cover property ($rose(pins.clk_o) && pins.dat_oe);
  cover property ($fell(pins.clk_o) && pins.clk_oe && !pins.dat_oe);
  cover property ($rose(irq));
endmodule : usm_serial_port_chk

bind usm_serial_port usm_serial_port_chk #(.DEPTH(DEPTH))
  usm_serial_port_chk_inst (.mclk(mclk), .srst(srst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .line_dat_i(line_dat_i), .pins(pins), .irq(irq));

// File: verilog/usm_pkg.sv
package usm_pkg;

  // ***************************************************
  // register indices (byte address is four times these)
  // ***************************************************
  localparam logic [7:0] IDX_INTCTL = 8'h0b;
  localparam logic [7:0] IDX_PIRF = 8'h0c;
  localparam logic [7:0] IDX_RCSC = 8'h18;
  localparam logic [7:0] IDX_TXBUF = 8'h19;
  localparam logic [7:0] IDX_RXBUF = 8'h1a;
  localparam logic [7:0] IDX_PIEN = 8'h8c;
  localparam logic [7:0] IDX_TXSC = 8'h98;
  localparam logic [7:0] IDX_BAUD = 8'h99;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int B_GIE = 7;
  localparam int B_PERIPH_IRQ_ENABLE = 6;
  localparam int B_RX_READY_FLAG = 5;
  localparam int B_TX_BUFFER_EMPTY_FLAG = 4;
  localparam int B_PORT_ENABLE = 7;
  localparam int B_RX9 = 6;
  localparam int B_SINGLE_RX_ENABLE = 5;
  localparam int B_CONTINUOUS_RX_ENABLE = 4;
  localparam int B_FRAMING_ERROR = 2;
  localparam int B_OVERRUN_ERROR = 1;
  localparam int B_RX_NINTH_BIT = 0;
  localparam int B_CLOCK_SOURCE_MASTER = 7;
  localparam int B_TX9 = 6;
  localparam int B_TX_ENABLE = 5;
  localparam int B_SYNC = 4;
  localparam int B_BAUD_HIGH_SPEED = 2;
  localparam int B_SHIFTER_EMPTY = 1;
  localparam int B_TX_NINTH_BIT = 0;

  // ***************************************************
  // reset values and counts
  // ***************************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TXSC = 8'h02;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [1:0] LOW_SPEED_LAST = 2'h3;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  localparam int RX_DEPTH = 2;

  // ***************************************************
  // carriers
  // ***************************************************
  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic dat_o;
    logic dat_oe;
  } usm_pins_t;

  typedef struct packed {
    logic framing_error;
    logic [8:0] data;
  } usm_rx_word_t;

  typedef enum logic [1:0] {
    arx_idle, arx_start, arx_data, arx_stop
  } usm_arx_t;

endpackage : usm_pkg

// File: verilog/usm_serial_port.sv
`timescale 1ns/1ps
// Operation
// R1: software loads divisor, speed bit before reception
// R2: async needs sync cleared, port enabled
// R3: interrupt needs source, peripheral, global enables
// R4: set nine-bit receive before enabling reception
// R5: receive-ready set on completion, gated interrupt
// R6: read status before receive buffer
// R7: clearing continuous receive resets receive errors; only overrun is cleared, queued framing errors stay
// R8: synchronous master is half-duplex
// R9: sync select and port enable claim pins
// R10: master bit drives shift clock
// R11: shifter reloads only after last bit
// R12: buffer-to-shifter takes one cycle, sets flag
// R13: buffer-empty flag cleared only by write
// R14: shifter-empty is read-only, no interrupt
// R15: data shifts on rising, stable at falling
// R16: baud generator held reset unless enabled
// R17: write to empty shifter passes straight through
// R18: clearing transmit enable aborts, releases pins
// R19: receive enable aborts transmit, keeps clock
// R20: single receive self-clears, transmit resumes
// R21: ninth bit taken at buffer transfer
// R22: software order for starting master transmit
// R23: two-deep receive queue, overrun stops transfers
// R24: framing error queued with data
// R25: receive-ready clears when queue empty
// R26: async receive samples at sixteen times baud
module usm_serial_port import usm_pkg::*; #(
  parameter int DEPTH = RX_DEPTH  // receive queue depth, power of two
) (
  input wire logic mclk,  // core clock
  input wire logic srst,  // synchronous reset, high
  input wire logic wb_cyc_i,  // wishbone cycle
  input wire logic wb_stb_i,  // wishbone strobe
  input wire logic wb_we_i,  // wishbone write
  input wire logic [9:0] wb_adr_i,  // wishbone byte address
  input wire logic [3:0] wb_sel_i,  // wishbone byte selects
  input wire logic [31:0] wb_dat_i,  // wishbone write data
  output logic [31:0] wb_dat_o,  // wishbone read data
  output logic wb_ack_o,  // wishbone acknowledge
  input wire logic line_dat_i,  // data line level from pin
  output usm_pins_t pins,  // clock and data line drive
  output logic irq  // serial port interrupt request
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // ***************************************************
  // registers and state
  // ***************************************************
  logic global_irq_enable, periph_irq_enable, port_enable, rx9, single_rx_enable, continuous_rx_enable;
  logic clock_source_master, tx9, tx_enable, sync_md, baud_high_speed, tx_ninth_bit;
  logic [7:0] pie, baud_div, tx_buf, brg_cnt;
  logic tx_full, tx_buffer_empty_flag, tx_enable_q, tx_busy, tx_dout, sclk, overrun_error;
  logic [8:0] tx_shift_register, rx_shift_register;
  logic [3:0] tx_cnt, rx_cnt, os_cnt;
  logic [1:0] pre_cnt;
  logic rxd_meta, rxd_s, rx_done, rx_framing_error;
  usm_arx_t arx;
  usm_rx_word_t rx_mem [DEPTH];
  logic [PW-1:0] wp, rp;
  logic [CW-1:0] rx_level;

  // ***************************************************
  // bus decode
  // ***************************************************
  logic acc, wr, rd, rx_any, brg_run, tick, stick, master;
  logic stx_act, srx_act, tx_load, rx_ready_flag, arx_on, push, pop;
  logic [7:0] idx, wdat;
  logic [3:0] last_bit;
  usm_rx_word_t head;

  // access strobes take effect on the acknowledged edge
  assign acc = wb_cyc_i & wb_stb_i;
  assign wr = acc & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign rd = acc & wb_ack_o & ~wb_we_i;
  assign idx = wb_adr_i[9:2];
  assign wdat = wb_dat_i[7:0];
  assign head = rx_mem[rp];
  assign last_bit = tx9 ? LAST_BIT9 : LAST_BIT8;

  // mode and enable terms
  assign rx_any = continuous_rx_enable | single_rx_enable;
  assign brg_run = tx_enable | rx_any;  // [R16]
  assign tick = brg_run & (brg_cnt == RST_ZERO);
  assign master = port_enable & sync_md & clock_source_master;  // [R9] [R10]
  assign srx_act = master & rx_any;  // [R8] [R19]
  assign stx_act = master & tx_enable & ~rx_any;  // [R8]
  assign tx_load = tx_enable & ~tx_busy & tx_full;  // [R11] [R17]
  assign rx_ready_flag = rx_level != '0;  // [R25]
  assign arx_on = port_enable & ~sync_md & continuous_rx_enable;
  assign push = rx_done & ~overrun_error;
  assign pop = rd & (idx == IDX_RXBUF) & rx_ready_flag;

  // ***************************************************
  // wishbone slave
  // ***************************************************
  // one-cycle acknowledge, registered read data
  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc & ~wb_ack_o;
      wb_dat_o <= '0;
      if (acc & ~wb_ack_o & ~wb_we_i) begin
        case (idx)
          IDX_INTCTL: wb_dat_o[7:6] <= {global_irq_enable, periph_irq_enable};
          IDX_PIRF: wb_dat_o[5:4] <= {rx_ready_flag, tx_buffer_empty_flag};
          IDX_RCSC: wb_dat_o[7:0] <= {port_enable, rx9, single_rx_enable, continuous_rx_enable, 1'b0,
                                      head.framing_error & rx_ready_flag, overrun_error,
                                      head.data[8] & rx_ready_flag};  // [R6] [R24]
          IDX_TXBUF: wb_dat_o[7:0] <= tx_buf;
          IDX_RXBUF: wb_dat_o[7:0] <= rx_ready_flag ? head.data[7:0] : 8'h00;
          IDX_PIEN: wb_dat_o[7:0] <= pie;
          IDX_TXSC: wb_dat_o[7:0] <= {clock_source_master, tx9, tx_enable, sync_md, 1'b0,
                                      baud_high_speed, ~tx_busy, tx_ninth_bit};  // [R14]
          IDX_BAUD: wb_dat_o[7:0] <= baud_div;
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // software-written control bits
  always_ff @(posedge mclk) begin
    if (srst) begin
      {global_irq_enable, periph_irq_enable} <= 2'b00;
      pie <= RST_ZERO;
      baud_div <= RST_ZERO;
      {port_enable, rx9, continuous_rx_enable} <= 3'b000;
      {clock_source_master, tx9, tx_enable, sync_md, baud_high_speed, tx_ninth_bit} <= 6'b000000;
    end else if (wr) begin
      case (idx)
        IDX_INTCTL: {global_irq_enable, periph_irq_enable} <= {wdat[B_GIE], wdat[B_PERIPH_IRQ_ENABLE]};
        IDX_PIEN: pie <= wdat;
        IDX_BAUD: baud_div <= wdat;
        IDX_RCSC: begin
          port_enable <= wdat[B_PORT_ENABLE];
          rx9 <= wdat[B_RX9];
          continuous_rx_enable <= wdat[B_CONTINUOUS_RX_ENABLE];
        end
        IDX_TXSC: begin
          clock_source_master <= wdat[B_CLOCK_SOURCE_MASTER];
          tx9 <= wdat[B_TX9];
          tx_enable <= wdat[B_TX_ENABLE];
          sync_md <= wdat[B_SYNC];
          baud_high_speed <= wdat[B_BAUD_HIGH_SPEED];
          tx_ninth_bit <= wdat[B_TX_NINTH_BIT];
        end
        default: ;
      endcase
    end
  end

  // single receive enable: software sets, end of word clears
  always_ff @(posedge mclk) begin
    if (srst) begin
      single_rx_enable <= 1'b0;
    end else if (wr & (idx == IDX_RCSC)) begin
      single_rx_enable <= wdat[B_SINGLE_RX_ENABLE];
    end else if (rx_done & srx_act & ~continuous_rx_enable) begin
      single_rx_enable <= 1'b0;  // [R20]
    end
  end

  // ***************************************************
  // transmit buffer and flag
  // ***************************************************
  // buffer fill and empty flag; same-cycle write keeps flag low
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_buf <= RST_ZERO;
      tx_full <= 1'b0;
      tx_buffer_empty_flag <= 1'b0;
      tx_enable_q <= 1'b0;
    end else begin
      tx_enable_q <= tx_enable;
      if (wr & (idx == IDX_TXBUF)) begin
        tx_buf <= wdat;
        tx_full <= 1'b1;
        tx_buffer_empty_flag <= 1'b0;  // [R13]
      end else if (tx_load) begin
        tx_full <= 1'b0;  // [R12]
        tx_buffer_empty_flag <= 1'b1;  // [R12] [R13]
      end else if (tx_enable & ~tx_enable_q & ~tx_full) begin
        tx_buffer_empty_flag <= 1'b1;
      end
    end
  end

  // ***************************************************
  // baud generator
  // ***************************************************
  // down counter reloading from the divisor, held while idle
  always_ff @(posedge mclk) begin
    if (srst | ~brg_run) begin
      brg_cnt <= RST_ZERO;  // [R16]
    end else if (tick) begin
      brg_cnt <= baud_div;
    end else begin
      brg_cnt <= brg_cnt - 8'h01;
    end
  end

  // shift clock phase, toggles on each tick while shifting
  always_ff @(posedge mclk) begin
    if (srst | ~master | ~brg_run) begin
      sclk <= 1'b0;
    end else if (tick & (srx_act | (stx_act & tx_busy))) begin
      sclk <= ~sclk;  // [R10]
    end
  end

  // ***************************************************
  // transmit shifter
  // ***************************************************
  // load, shift on falling edge, abort on enable clear
  always_ff @(posedge mclk) begin
    if (srst | ~tx_enable) begin
      tx_busy <= 1'b0;  // [R18]
      tx_cnt <= 4'h0;
      tx_dout <= 1'b0;
      tx_shift_register <= '0;
    end else if (tx_load) begin
      tx_shift_register <= {tx9 & tx_ninth_bit, tx_buf};  // [R21]
      tx_busy <= 1'b1;  // [R12]
      tx_cnt <= 4'h0;
    end else if (stx_act & tx_busy & tick) begin
      if (~sclk) begin
        tx_dout <= tx_shift_register[0];  // [R15]
      end else begin
        tx_shift_register <= {1'b0, tx_shift_register[8:1]};
        tx_cnt <= tx_cnt + 4'h1;
        if (tx_cnt == last_bit) begin
          tx_busy <= 1'b0;  // [R11]
        end
      end
    end
  end

  // ***************************************************
  // receive line synchroniser
  // ***************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxd_meta <= 1'b1;
      rxd_s <= 1'b1;
    end else begin
      rxd_meta <= line_dat_i;
      rxd_s <= rxd_meta;
    end
  end

  // sample tick: every tick at high speed, else every fourth
  always_ff @(posedge mclk) begin
    if (srst | ~brg_run) begin
      pre_cnt <= 2'h0;
    end else if (tick) begin
      pre_cnt <= pre_cnt + 2'h1;
    end
  end
  assign stick = tick & (baud_high_speed | (pre_cnt == LOW_SPEED_LAST));

  // ***************************************************
  // receive shifter, async and sync master
  // ***************************************************
  // async sixteen-times sampling and sync falling-edge sampling
  always_ff @(posedge mclk) begin
    if (srst | ~(arx_on | srx_act)) begin
      arx <= arx_idle;
      os_cnt <= 4'h0;
      rx_cnt <= 4'h0;
      rx_shift_register <= '0;
      rx_done <= 1'b0;
      rx_framing_error <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (srx_act) begin
        rx_framing_error <= 1'b0;
        if (tick & sclk) begin
          rx_shift_register <= {rxd_s, rx_shift_register[8:1]};
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt == (rx9 ? LAST_BIT9 : LAST_BIT8)) begin
            rx_cnt <= 4'h0;
            rx_done <= 1'b1;  // [R20]
          end
        end
      end else begin
        case (arx)
          arx_idle: begin
            os_cnt <= 4'h0;
            if (~rxd_s) arx <= arx_start;
          end
          arx_start: if (stick) begin
            os_cnt <= os_cnt + 4'h1;
            if (os_cnt == OS_MID) begin
              os_cnt <= 4'h0;
              rx_cnt <= 4'h0;
              arx <= rxd_s ? arx_idle : arx_data;
            end
          end
          arx_data: if (stick) begin
            os_cnt <= os_cnt + 4'h1;  // [R26]
            if (os_cnt == OS_LAST) begin
              rx_shift_register <= {rxd_s, rx_shift_register[8:1]};
              rx_cnt <= rx_cnt + 4'h1;
              if (rx_cnt == (rx9 ? LAST_BIT9 : LAST_BIT8)) begin
                arx <= arx_stop;
              end
            end
          end
          arx_stop: if (stick) begin
            os_cnt <= os_cnt + 4'h1;
            if (os_cnt == OS_LAST) begin
              rx_framing_error <= ~rxd_s;  // [R24]
              rx_done <= 1'b1;
              arx <= arx_idle;
            end
          end
          default: arx <= arx_idle;
        endcase
      end
    end
  end

  // ***************************************************
  // receive queue
  // ***************************************************
  // two-deep queue with overrun; error cleared with continuous_rx_enable
  always_ff @(posedge mclk) begin
    if (srst) begin
      wp <= '0;
      rp <= '0;
      rx_level <= '0;
      overrun_error <= 1'b0;
    end else begin
      if (~continuous_rx_enable) begin
        overrun_error <= 1'b0;  // [R7]
      end else if (rx_done & (rx_level == CW'(DEPTH)) & ~pop) begin
        overrun_error <= 1'b1;  // [R23]
      end
      if (push & ((rx_level != CW'(DEPTH)) | pop)) begin
        rx_mem[wp] <= '{framing_error: rx_framing_error,
                        data: rx9 ? rx_shift_register : {1'b0, rx_shift_register[8:1]}};  // [R24]
        wp <= wp + PW'(1);
      end
      if (pop) rp <= rp + PW'(1);
      case ({push & ((rx_level != CW'(DEPTH)) | pop), pop})
        2'b10: rx_level <= rx_level + CW'(1);  // [R5]
        2'b01: rx_level <= rx_level - CW'(1);  // [R25]
        default: rx_level <= rx_level;
      endcase
    end
  end

  // ***************************************************
  // pins and interrupt
  // ***************************************************
  // clock line driven in master mode while the generator runs
  always_comb begin
    pins.clk_o = sclk;
    pins.clk_oe = master & brg_run;  // [R10] [R18] [R19]
    pins.dat_o = tx_dout;
    pins.dat_oe = stx_act;  // [R19] [R20]
  end

  // interrupt request gated by source and shared enables
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= global_irq_enable & periph_irq_enable & ((rx_ready_flag & pie[B_RX_READY_FLAG]) |
                           (tx_buffer_empty_flag & pie[B_TX_BUFFER_EMPTY_FLAG]));  // [R3] [R5]
    end
  end

endmodule : usm_serial_port
